/* File: fault_inj_pkg.sv */
package fault_inj_pkg;

   // one bit per detector; fault and warning detectors side by side
   typedef struct packed {
      logic overtemperature;
      logic overcurrent_fault;
      logic input_lockout;
      logic input_overvoltage;
      logic output_undervoltage_fault;
      logic output_overvoltage_fault;
      logic overcurrent_warning;
      logic input_undervoltage_warning;
      logic output_undervoltage_warning;
      logic output_overvoltage_warning;
   } cond_t;

   // one command as decoded by the protocol engine
   typedef struct packed {
      logic valid;      // one-cycle strobe
      logic write;      // 1 write, 0 read
      logic block;      // block transfer rather than word
      logic [7:0] code; // command code
      logic [15:0] wdata;
   } cmd_req_t;

   // answer to that command, one cycle later
   typedef struct packed {
      logic valid;      // one-cycle strobe
      logic ack;        // command is supported
      logic cml_error;  // raise a communication error
      logic [3:0] len;  // bytes of read data
      logic [47:0] rdata;
   } cmd_rsp_t;

endpackage : fault_inj_pkg

/* File: fault_inj_regs.svh */
`ifndef FAULT_INJ_REGS_SVH
`define FAULT_INJ_REGS_SVH

// command codes of the three commands handled here
`define FI_CMD_INJECT 8'hf1
`define FI_CMD_ID_WORD 8'hfc
`define FI_CMD_ID_BLOCK 8'hfd

// injection register bit positions
`define FI_BIT_FAULT_PERSIST 15
`define FI_BIT_OVERTEMP 14
`define FI_BIT_OC_FAULT 12
`define FI_BIT_IN_LOCKOUT 11
`define FI_BIT_IN_OV 10
`define FI_BIT_OUT_UV_FAULT 9
`define FI_BIT_OUT_OV_FAULT 8
`define FI_BIT_WARN_PERSIST 7
`define FI_BIT_OC_WARN 4
`define FI_BIT_IN_UV_WARN 3
`define FI_BIT_OUT_UV_WARN 1
`define FI_BIT_OUT_OV_WARN 0

// reset value of the fault half, bits 15:8
`define FI_FAULT_HALF_RESET 8'h00

// answer lengths in bytes
`define FI_LEN_WORD 4'h2
`define FI_LEN_BLOCK 4'h6
`define FI_LEN_NONE 4'h0

`endif

/* File: fault_injection_and_id_regs.sv */
// Notes on behaviour
// (RL1) no fault persist: clear after one response
// (RL2) fault persist: hold until next register write
// (RL3) no warning persist: clear after one response
// (RL4) warning persist: hold until next register write
// (RL5) fault bits inject their matching fault
// (RL6) warning bits inject their matching warning
// (RL7) zero injects nothing; spare bits are storage
// (RL8) conversion off: only lockout and output overvoltage
// (RL9) other injections act only while converting
// (RL10) several injections may act at once
// (RL11) word write to word code acked, discarded
// (RL12) identification writes leave read-back unchanged
// (RL13) identification writes raise no communication error
// (RL14) word code returns fixed sixteen-bit value
// (RL15) block write to block code accepted, ignored
// (RL16) block code returns six fixed bytes
// (RL17) injection ORed onto the real detector outputs
`timescale 1ns/10ps
`include "fault_inj_regs.svh"

module fault_injection_and_id_regs #(
   // reset value of warning half, bits 7:0
   parameter logic [7:0] WARN_HALF_RESET = 8'h00,
   // identification values; arbitrary, chosen neutral
   parameter logic [15:0] ID_WORD_VALUE = 16'h1a2b,
   // identification values; arbitrary, chosen neutral
   parameter logic [47:0] ID_BLOCK_VALUE = 48'h313233343536
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   // decoded command from the protocol engine
   input wire fault_inj_pkg::cmd_req_t cmd_req_i,
   // answer back to the protocol engine
   output fault_inj_pkg::cmd_rsp_t cmd_rsp_o,
   // raw comparator outputs, asynchronous
   input wire fault_inj_pkg::cond_t detector_raw_i,
   // conversion enabled, same clock domain
   input wire logic conversion_enabled_i,
   // one response carried out, per detector, pulse
   input wire fault_inj_pkg::cond_t response_done_i,
   // detector outputs after injection
   output fault_inj_pkg::cond_t detector_o,
   // current injection register contents
   output logic [15:0] injection_reg_o
);
   import fault_inj_pkg::*;

   // synchronised comparator levels
   logic [9:0] detector_sync;
   // the injection register itself
   logic [15:0] fault_injection_control;
   // next value of the register
   logic [15:0] next_injection;
   // injection requests decoded from the register
   cond_t injected;
   // injections allowed to act in this cycle
   cond_t effective;
   // bits to be cleared by a completed response
   logic [15:0] auto_clear;
   // request decode strobes
   logic hit_inject;
   logic hit_id_word;
   logic hit_id_block;
   logic inject_write;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // register bits to per-detector injection requests
   function automatic cond_t decode_injection(input logic [15:0] r);
      cond_t c;
      c.overtemperature = r[`FI_BIT_OVERTEMP]; // see (RL5)
      c.overcurrent_fault = r[`FI_BIT_OC_FAULT]; // see (RL5)
      c.input_lockout = r[`FI_BIT_IN_LOCKOUT]; // see (RL5)
      c.input_overvoltage = r[`FI_BIT_IN_OV]; // see (RL5)
      c.output_undervoltage_fault = r[`FI_BIT_OUT_UV_FAULT]; // see (RL5)
      c.output_overvoltage_fault = r[`FI_BIT_OUT_OV_FAULT]; // see (RL5)
      c.overcurrent_warning = r[`FI_BIT_OC_WARN]; // see (RL6)
      c.input_undervoltage_warning = r[`FI_BIT_IN_UV_WARN]; // see (RL6)
      c.output_undervoltage_warning = r[`FI_BIT_OUT_UV_WARN]; // see (RL6)
      c.output_overvoltage_warning = r[`FI_BIT_OUT_OV_WARN]; // see (RL6)
      return c;
   endfunction : decode_injection

   // per-detector flags back to register bit positions;
   // spare and persist bits never appear in the result
   function automatic logic [15:0] place_bits(input cond_t c);
      logic [15:0] m;
      m = 16'h0000;
      m[`FI_BIT_OVERTEMP] = c.overtemperature;
      m[`FI_BIT_OC_FAULT] = c.overcurrent_fault;
      m[`FI_BIT_IN_LOCKOUT] = c.input_lockout;
      m[`FI_BIT_IN_OV] = c.input_overvoltage;
      m[`FI_BIT_OUT_UV_FAULT] = c.output_undervoltage_fault;
      m[`FI_BIT_OUT_OV_FAULT] = c.output_overvoltage_fault;
      m[`FI_BIT_OC_WARN] = c.overcurrent_warning;
      m[`FI_BIT_IN_UV_WARN] = c.input_undervoltage_warning;
      m[`FI_BIT_OUT_UV_WARN] = c.output_undervoltage_warning;
      m[`FI_BIT_OUT_OV_WARN] = c.output_overvoltage_warning;
      return m;
   endfunction : place_bits

   // fault-half mask: bits 15:8 of the register
   function automatic logic [15:0] fault_half(input logic [15:0] m);
      return {m[15:8], 8'h00};
   endfunction : fault_half

   // warning-half mask: bits 7:0 of the register
   function automatic logic [15:0] warn_half(input logic [15:0] m);
      return {8'h00, m[7:0]};
   endfunction : warn_half

   // ----------------------------------------------------------------
   // comparator synchronisation
   // ----------------------------------------------------------------

   // comparators are asynchronous to the core clock
   level_sync #(
      .WIDTH(10)
   ) u_detector_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .async_i(detector_raw_i),
      .sync_o(detector_sync)
   );

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------

   // which of our commands this request addresses
   always_comb begin
      hit_inject = cmd_req_i.valid && (cmd_req_i.code == `FI_CMD_INJECT);
      hit_id_word = cmd_req_i.valid && (cmd_req_i.code == `FI_CMD_ID_WORD);
      hit_id_block = cmd_req_i.valid
                     && (cmd_req_i.code == `FI_CMD_ID_BLOCK);
      // only a word write may load the injection register
      inject_write = hit_inject && cmd_req_i.write && !cmd_req_i.block;
   end

   // ----------------------------------------------------------------
   // injection gating
   // ----------------------------------------------------------------

   // several bits may be set together, each acts on its own line
   always_comb begin
      injected = decode_injection(fault_injection_control); // see (RL10)
      effective = injected;
      if (!conversion_enabled_i) begin
         // while idle only lockout and output overvoltage act;
         // the rest wait so persistent ones cycle shutdown/restart
         effective = '0; // see (RL9)
         effective.input_lockout = injected.input_lockout; // see (RL8)
         effective.output_overvoltage_fault =
            injected.output_overvoltage_fault; // see (RL8)
      end
   end

   // ----------------------------------------------------------------
   // automatic removal after one response
   // ----------------------------------------------------------------

   // a response only counts for an injection that was acting
   always_comb begin
      auto_clear = place_bits(effective & response_done_i);
      // persist set: nothing but a new write removes them
      if (fault_injection_control[`FI_BIT_FAULT_PERSIST]) begin
         auto_clear = warn_half(auto_clear); // see (RL2)
      end
      if (fault_injection_control[`FI_BIT_WARN_PERSIST]) begin
         auto_clear = fault_half(auto_clear); // see (RL4)
      end
   end

   // next register value; a host write wins over auto removal,
   // so an injection written in the clearing cycle is kept
   always_comb begin
      if (inject_write) begin
         // stores every bit; a zero simply injects nothing
         next_injection = cmd_req_i.wdata; // see (RL7)
      end else begin
         // one response done: drop fault and warning bits
         next_injection = fault_injection_control
                          & ~auto_clear; // see (RL1) see (RL3)
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------

   // injection register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fault_injection_control <= {`FI_FAULT_HALF_RESET,
                                     WARN_HALF_RESET};
      end else begin
         fault_injection_control <= next_injection;
      end
   end

   // register contents shown to the rest of the device
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         injection_reg_o <= {`FI_FAULT_HALF_RESET, WARN_HALF_RESET};
      end else begin
         injection_reg_o <= next_injection;
      end
   end

   // detector outputs: real event or injected one, same path
   // onward, so status and response logic cannot tell them apart
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         detector_o <= '0;
      end else begin
         detector_o <= cond_t'(detector_sync) | effective; // see (RL17)
      end
   end

   // ----------------------------------------------------------------
   // command answers
   // ----------------------------------------------------------------

   // answer one cycle after each request strobe
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cmd_rsp_o <= '0;
      end else begin
         // defaults: strobe follows the request, no ack, no data
         cmd_rsp_o.valid <= cmd_req_i.valid;
         cmd_rsp_o.ack <= 1'b0;
         cmd_rsp_o.cml_error <= 1'b0;
         cmd_rsp_o.len <= `FI_LEN_NONE;
         cmd_rsp_o.rdata <= '0;
         if (hit_inject) begin
            // injection register, word access only
            cmd_rsp_o.ack <= !cmd_req_i.block;
            cmd_rsp_o.cml_error <= cmd_req_i.block;
            if (!cmd_req_i.write && !cmd_req_i.block) begin
               cmd_rsp_o.len <= `FI_LEN_WORD;
               cmd_rsp_o.rdata <= {32'h0000_0000,
                                   fault_injection_control};
            end
         end else if (hit_id_word) begin
            // writes acked, data dropped, no error raised
            cmd_rsp_o.ack <= 1'b1; // see (RL11) see (RL13)
            if (!cmd_req_i.write) begin
               // fixed value, no storage to disturb
               cmd_rsp_o.len <= `FI_LEN_WORD; // see (RL12)
               cmd_rsp_o.rdata <= {32'h0000_0000,
                                   ID_WORD_VALUE}; // see (RL14)
            end
         end else if (hit_id_block) begin
            // block write accepted and ignored, no error raised
            cmd_rsp_o.ack <= 1'b1; // see (RL15) see (RL13)
            if (!cmd_req_i.write) begin
               // bytes 47:40 first on the wire
               cmd_rsp_o.len <= `FI_LEN_BLOCK; // see (RL12)
               cmd_rsp_o.rdata <= ID_BLOCK_VALUE; // see (RL16)
            end
         end else if (cmd_req_i.valid) begin
            // not ours; other decoders may claim it, flag nothing
            cmd_rsp_o.ack <= 1'b0;
         end
      end
   end

endmodule : fault_injection_and_id_regs

/* File: fi_properties.sv */
`timescale 1ns/10ps
// port-level checker for the injection and identification bank
module fi_properties #(
   parameter logic [7:0] WARN_HALF_RESET = 8'h00,
   parameter logic [15:0] ID_WORD_VALUE = 16'h1a2b,
   parameter logic [47:0] ID_BLOCK_VALUE = 48'h313233343536
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire fault_inj_pkg::cmd_req_t cmd_req_i,
   input wire fault_inj_pkg::cmd_rsp_t cmd_rsp_o,
   input wire fault_inj_pkg::cond_t detector_raw_i,
   input wire logic conversion_enabled_i,
   input wire fault_inj_pkg::cond_t response_done_i,
   input wire fault_inj_pkg::cond_t detector_o,
   input wire logic [15:0] injection_reg_o
);
   import fault_inj_pkg::*;
   // edges since reset; raw path is trusted only once the sync has filled
   logic [2:0] since_rst;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         since_rst <= 3'h0;
      end else if (since_rst != 3'h4) begin
         since_rst <= since_rst + 3'h1;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // one request of given direction and code
   sequence s_req(logic wr, logic [7:0] c);
      cmd_req_i.valid && cmd_req_i.write == wr && cmd_req_i.code == c;
   endsequence
   // gate closed and raw quiet long enough to flush the sync
   sequence s_off_quiet;
      (!conversion_enabled_i && detector_raw_i == '0) [*4];
   endsequence
   a_rsp_follows: assert property (cmd_req_i.valid |=> cmd_rsp_o.valid)
      else $error("no answer one cycle after request");
   a_rsp_quiet: assert property (!cmd_req_i.valid |=> !cmd_rsp_o.valid)
      else $error("answer without request");
   a_word_read: assert property (s_req(1'b0, 8'hfc) ##0 !cmd_req_i.block
      |=> cmd_rsp_o.ack && cmd_rsp_o.len == 4'h2
      && cmd_rsp_o.rdata[15:0] == ID_WORD_VALUE)
      else $error("word code read wrong");
   a_block_read: assert property (s_req(1'b0, 8'hfd) ##0 cmd_req_i.block
      |=> cmd_rsp_o.len == 4'h6 && cmd_rsp_o.rdata == ID_BLOCK_VALUE)
      else $error("block code read wrong");
   a_id_write_ok: assert property ((s_req(1'b1, 8'hfc) or s_req(1'b1, 8'hfd))
      |=> cmd_rsp_o.ack && !cmd_rsp_o.cml_error)
      else $error("id write refused or flagged");
   a_inject_store: assert property (s_req(1'b1, 8'hf1) ##0 !cmd_req_i.block
      |=> injection_reg_o == $past(cmd_req_i.wdata))
      else $error("injection write not stored");
   a_lockout_acts: assert property (injection_reg_o[11]
      |=> detector_o.input_lockout)
      else $error("lockout injection not driven");
   a_gate_off: assert property (s_off_quiet
      |=> (detector_o & 10'h36f) == 10'h000)
      else $error("gated injection acts while off");
   a_raw_passes: assert property (since_rst == 3'h4
      |-> (detector_o & $past(detector_raw_i, 3)) == $past(detector_raw_i, 3))
      else $error("raw detector not passed");
   a_fault_autoclr: assert property (!cmd_req_i.valid && !injection_reg_o[15]
      && injection_reg_o[12] && conversion_enabled_i
      && $past(conversion_enabled_i) && response_done_i.overcurrent_fault
      |=> !injection_reg_o[12])
      else $error("fault injection not cleared");
   a_persist_hold: assert property (!cmd_req_i.valid && injection_reg_o[15]
      && injection_reg_o[7] |=> $stable(injection_reg_o))
      else $error("persistent injection lost");
endmodule : fi_properties

/* File: level_sync.sv */
`timescale 1ns/10ps

// two flip-flop synchroniser for a bundle of independent levels
module level_sync #(
   parameter int WIDTH = 10
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   // first stage; read by the second stage only
   logic [WIDTH-1:0] meta;

   // both stages clear on reset so no stale level leaks out
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule : level_sync

/* File: pmbus_host_model.sv */
`timescale 1ns/10ps
// host side: hands decoded commands to the bank, one at a time
module pmbus_host_model (
   input wire logic core_clk_i,
   output fault_inj_pkg::cmd_req_t cmd_req_o,
   input wire fault_inj_pkg::cmd_rsp_t cmd_rsp_i
);
   import fault_inj_pkg::*;
   initial cmd_req_o = '0;
   // one-cycle request; answer stands one cycle, so take it at once
   task automatic xfer(input logic wr, input logic blk,
      input logic [7:0] code, input logic [15:0] wd, output cmd_rsp_t rsp);
      @(negedge core_clk_i);
      cmd_req_o <= '{1'b1, wr, blk, code, wd};
      @(negedge core_clk_i);
      cmd_req_o <= '0;
      rsp = cmd_rsp_i;
   endtask : xfer
endmodule : pmbus_host_model

/* File: tb_fault_injection_and_id_regs.sv */
`timescale 1ns/10ps
module tb_fault_injection_and_id_regs;
   import fault_inj_pkg::*;
   localparam logic [15:0] IDW = 16'h1a2b; // arbitrary code
   localparam logic [47:0] IDB = 48'h313233343536; // arbitrary code
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic conv = 1'b0;
   cond_t raw = '0;
   cond_t done = '0;
   cond_t det;
   cmd_req_t cmd_req;
   cmd_rsp_t cmd_rsp;
   cmd_rsp_t rsp;
   logic [15:0] inj_reg;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   int pos[10] = '{14, 12, 11, 10, 9, 8, 4, 3, 1, 0}; // cond_t order
   // request, then expected ack, cml, len, rdata and register
   typedef struct {
      logic wr; logic blk; logic [7:0] code; logic [15:0] wd;
      logic ack; logic cml; logic [3:0] len; logic [47:0] rd;
      logic [15:0] reg_v;
   } row_t;
   row_t rows[10] = '{
      '{0, 0, 8'hfc, 0, 1, 0, 2, IDW, 0},
      '{1, 0, 8'hfc, 16'hffff, 1, 0, 0, 0, 0},
      '{0, 0, 8'hfc, 0, 1, 0, 2, IDW, 0},
      '{1, 1, 8'hfd, 16'h5555, 1, 0, 0, 0, 0},
      '{0, 1, 8'hfd, 0, 1, 0, 6, IDB, 0},
      '{1, 0, 8'hf1, 16'h2064, 1, 0, 0, 0, 16'h2064},
      '{1, 1, 8'hf1, 16'hffff, 0, 1, 0, 0, 16'h2064},
      '{0, 0, 8'hf1, 0, 1, 0, 2, 48'h2064, 16'h2064},
      '{0, 0, 8'h55, 0, 0, 0, 0, 0, 16'h2064},
      '{1, 0, 8'hf1, 0, 1, 0, 0, 0, 0}};
   always #5 core_clk_i = ~core_clk_i;
   fault_injection_and_id_regs #(.WARN_HALF_RESET(8'h00),
      .ID_WORD_VALUE(IDW), .ID_BLOCK_VALUE(IDB)) dut_u (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_req_i(cmd_req),
      .cmd_rsp_o(cmd_rsp), .detector_raw_i(raw),
      .conversion_enabled_i(conv), .response_done_i(done),
      .detector_o(det), .injection_reg_o(inj_reg));
   pmbus_host_model host_u (.core_clk_i(core_clk_i), .cmd_req_o(cmd_req),
      .cmd_rsp_i(cmd_rsp));
   // compare and count; unknowns never match
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // word write to the injection register
   task automatic inject(input logic [15:0] v);
      host_u.xfer(1'b1, 1'b0, 8'hf1, v, rsp);
   endtask : inject
   // one response carried out on every detector
   task automatic pulse_done();
      done <= '1;
      @(negedge core_clk_i);
      done <= '0;
      repeat (2) @(negedge core_clk_i);
   endtask : pulse_done
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   // hang guard; whole run needs under a hundred cycles
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      repeat (4) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk(48'(inj_reg), 48'h0);
      chk(48'(det), 48'h0);
      $display("test reset finished");
      foreach (rows[i]) begin
         host_u.xfer(rows[i].wr, rows[i].blk, rows[i].code, rows[i].wd, rsp);
         chk(48'({rsp.ack, rsp.cml_error, rsp.len}),
             48'({rows[i].ack, rows[i].cml, rows[i].len}));
         chk(rsp.rdata & ((48'h1 << (8 * rows[i].len)) - 48'h1),
             rows[i].rd);
         chk(48'(inj_reg), 48'(rows[i].reg_v));
         chk(48'(det), 48'h0);
      end
      $display("test rows finished");
      conv = 1'b1;
      // each bit alone drives only its own detector
      for (int i = 0; i < 10; i++) begin
         inject(16'h8080 | (16'h1 << pos[i]));
         @(negedge core_clk_i);
         chk(48'(det), 48'(10'h200 >> i));
      end
      inject(16'hdf9b);
      @(negedge core_clk_i);
      chk(48'(det), 48'h3ff);
      pulse_done();
      chk(48'(inj_reg), 48'hdf9b);
      conv = 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk(48'(det), 48'h090);
      conv = 1'b1;
      $display("test mapping finished");
      inject(16'h1010);
      @(negedge core_clk_i);
      chk(48'(det), 48'h108);
      pulse_done();
      chk(48'(inj_reg), 48'h0);
      chk(48'(det), 48'h0);
      raw = 10'h040;
      repeat (4) @(negedge core_clk_i);
      chk(48'(det), 48'h040);
      raw = '0;
      inject(16'h0800);
      rst_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk(48'(inj_reg), 48'h0);
      repeat (4) @(negedge core_clk_i);
      $display("test autoclear and reset finished");
      close_out();
   end
endmodule : tb_fault_injection_and_id_regs
bind fault_injection_and_id_regs fi_properties #(
   .WARN_HALF_RESET(WARN_HALF_RESET), .ID_WORD_VALUE(ID_WORD_VALUE),
   .ID_BLOCK_VALUE(ID_BLOCK_VALUE)) chk_u (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_req_i(cmd_req_i),
   .cmd_rsp_o(cmd_rsp_o), .detector_raw_i(detector_raw_i),
   .conversion_enabled_i(conversion_enabled_i),
   .response_done_i(response_done_i), .detector_o(detector_o),
   .injection_reg_o(injection_reg_o));
